// file: verilog/rds_output_ctrl.sv
/*
  output and handshake control of the radio data block decoder: picks
  when the last two blocks are released, drives the data-available
  strobe, guards against overflow and keeps the reset-seen flag.
  assumes the block detector and flywheel sit outside on the same clock
  and that a serial register interface reports reads as one-cycle pulses.
*/
// Overview of operation
// - mode four while searching: correctable blocks count as bad blocks
// - mode four synced: up to five-bit corrected is good, uncorrectable bad
// - select 00 synced: release last two blocks every 26-bit block
// - select 01 searching: release on each valid A or C'; synced acts standard
// - select 10 synced: release once per two blocks, 52 bits
// - select 11 holds decoder output select low, bypassing the decoder
// - release gives both identities, words, error codes and status
// - overflow set if synced block arrives before last one was read
// - overflow suppresses updates until read-clear or sync restart
// - select 01 searching: strobe low on valid A or C' block
// - strobe when sync criterion met, except in bypass
// - synced strobe per block in 00/01, per two blocks in 10
// - strobe on flywheel loss of sync, except in bypass
// - strobe when power reset input goes low, except in bypass
// - synced strobe is periodic whether blocks were valid or not
// - released data stays readable at least 20 ms after strobe
// - strobe releases after about 10 ms or on status byte read
// - new blocks are dropped while strobe or overflow is active
// - block identity is a three-bit code, A through invalid
// - error status is a two-bit code, none through uncorrectable
// - reset-seen flag set while power reset input is low, cleared on status read
// - sync restart command aborts sync and clears itself when done
`timescale 1ns/1ns
`default_nettype none
module rds_output_ctrl
  import rds_out_pkg::*;
#(
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins from outside the clock domain
  input wire logic rds_bit_clk,
  input wire logic power_reset_n,
  // mode selects
  input wire logic sync_err_mode_hi,
  input wire logic sync_err_mode_lo,
  input wire logic output_mode_sel_hi,
  input wire logic output_mode_sel_lo,
  // block detector and flywheel events
  input wire logic block_done,
  input wire logic [2:0] block_id,
  input wire logic [1:0] block_err,
  input wire logic [WORD_W-1:0] block_word,
  input wire logic synced,
  input wire logic seq_pair_found,
  input wire logic flywheel_loss,
  // serial register interface events
  input wire logic block_read_done,
  input wire logic status_read,
  input wire logic sync_restart_cmd,
  output logic sync_restart_ack,
  // flywheel counter steps
  output logic good_inc,
  output logic bad_inc,
  // released data
  output logic [2:0] last_id,
  output logic [2:0] prev_id,
  output logic [WORD_W-1:0] last_word,
  output logic [WORD_W-1:0] prev_word,
  output logic [1:0] last_err,
  output logic [1:0] prev_err,
  output logic status_synced,
  output logic overflow_flag,
  output logic reset_seen_flag,
  output logic iface_write_enable,
  // strobe and mux
  output logic data_avail_n,
  output logic decoder_out_select
);
  typedef struct packed {
    strobe_state_type st;
    logic [4:0] bit_cnt;
    logic bclk_prev;
    logic pres_prev;
    logic pair_ph;
    logic read_out;
    logic ovf;
    logic rst_seen;
    logic ack;
    logic good;
    logic bad;
    logic wr;
    logic strobe_n;
    logic [2:0] sh_last_id;
    logic [2:0] sh_prev_id;
    logic [WORD_W-1:0] sh_last_word;
    logic [WORD_W-1:0] sh_prev_word;
    logic [1:0] sh_last_err;
    logic [1:0] sh_prev_err;
    logic [2:0] o_last_id;
    logic [2:0] o_prev_id;
    logic [WORD_W-1:0] o_last_word;
    logic [WORD_W-1:0] o_prev_word;
    logic [1:0] o_last_err;
    logic [1:0] o_prev_err;
    logic o_synced;
  } ctrl_state_type;

  ctrl_state_type st_reg;
  ctrl_state_type st_next;
  logic bclk_s;
  logic pres_s;
  logic [1:0] osel;
  logic [1:0] sym;
  logic bypass;
  logic bit_rise;
  logic slot;
  logic blk_valid;
  logic blk_good;
  logic rel_any;
  logic fire;
  logic strobe_done;
  logic hold_done;
  logic hold_busy;

  // link clock and power reset pins are resynchronised first
  pin_sync #(.W(2), .INIT(2'h1)) u_pins (
    .clk(clk),
    .rstn(rstn),
    .d({rds_bit_clk, power_reset_n}),
    .q({bclk_s, pres_s})
  );

  // strobe release and data hold periods
  down_timer #(.W(TIMER_W), .LOAD(TIMER_W'(STROBE_CYCLES))) u_strobe_tmr (
    .clk(clk),
    .rstn(rstn),
    .start(fire),
    .stop(status_read),
    .busy(),
    .done(strobe_done)
  );
  down_timer #(.W(TIMER_W), .LOAD(TIMER_W'(HOLD_CYCLES))) u_hold_tmr (
    .clk(clk),
    .rstn(rstn),
    .start(fire),
    .stop(1'b0),
    .busy(hold_busy),
    .done(hold_done)
  );

  // decoded modes and link timing
  assign osel = {output_mode_sel_hi, output_mode_sel_lo};
  assign sym = {sync_err_mode_hi, sync_err_mode_lo};
  assign bypass = (osel == OSEL_BYPASS);
  assign bit_rise = bclk_s && !st_reg.bclk_prev;
  assign slot = bit_rise && (st_reg.bit_cnt == BITS_PER_BLOCK - 5'h01);
  assign blk_valid = (block_err != ERR_UNCORR) && (block_id != ID_INVALID)
                     && (block_id != ID_E_BAD);

  // good block classification per error-handling mode
  always_comb begin
    case (sym)
      SYM_NONE: blk_good = (block_err == ERR_NONE);
      SYM_2BIT: blk_good = (block_err <= ERR_2BIT);
      SYM_5BIT: blk_good = (block_err <= ERR_5BIT);
      // mode four depends on sync state
      SYM_FOUR: blk_good = synced ? (block_err != ERR_UNCORR)
                                  : (block_err == ERR_NONE);
      default: blk_good = 1'b0;
    endcase
  end

  // release sources, none of them in bypass
  always_comb begin
    rel_any = 1'b0;
    // fast search on valid A or C'
    if (osel == OSEL_FAST && !synced && block_done && blk_valid &&
        (block_id == ID_A || block_id == ID_C_PRIME)) begin
      rel_any = 1'b1;
    end
    if (seq_pair_found) begin
      rel_any = 1'b1;
    end
    if (synced && slot && (osel != OSEL_REDUCED || st_reg.pair_ph)) begin
      rel_any = 1'b1;
    end
    if (synced && flywheel_loss) begin
      rel_any = 1'b1;
    end
    if (!pres_s && st_reg.pres_prev) begin
      rel_any = 1'b1;
    end
    if (bypass) begin
      rel_any = 1'b0;
    end
  end

  // no release while strobe, hold or overflow is active
  assign fire = rel_any && (st_reg.st == ST_IDLE) && !st_reg.ovf;

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.bclk_prev = bclk_s;
    st_next.pres_prev = pres_s;
    st_next.good = 1'b0;
    st_next.bad = 1'b0;
    st_next.wr = fire;
    // bit counter realigns on sync so slots match block borders
    if (seq_pair_found) begin
      st_next.bit_cnt = 5'h00;
    end else if (bit_rise) begin
      st_next.bit_cnt = slot ? 5'h00 : st_reg.bit_cnt + 5'h01;
    end
    // pair phase toggles once per synced slot
    if (!synced) begin
      st_next.pair_ph = 1'b0;
    end else if (slot) begin
      st_next.pair_ph = !st_reg.pair_ph;
    end
    // one counter step per processed block
    if (block_done) begin
      st_next.good = blk_good;
      st_next.bad = !blk_good;
    end
    // capture block unless strobe or overflow is active
    if (block_done && st_reg.st != ST_ACTIVE && !st_reg.ovf) begin
      st_next.sh_prev_id = st_reg.sh_last_id;
      st_next.sh_prev_word = st_reg.sh_last_word;
      st_next.sh_prev_err = st_reg.sh_last_err;
      st_next.sh_last_id = block_id;
      st_next.sh_last_word = block_word;
      st_next.sh_last_err = block_err;
    end
    // release copies both blocks and status to the outputs
    // a block taken at this very edge belongs to the release, so the
    // copy reads the shadow after capture, not the registered one
    if (fire) begin
      st_next.o_last_id = st_next.sh_last_id;
      st_next.o_prev_id = st_next.sh_prev_id;
      st_next.o_last_word = st_next.sh_last_word;
      st_next.o_prev_word = st_next.sh_prev_word;
      st_next.o_last_err = st_next.sh_last_err;
      st_next.o_prev_err = st_next.sh_prev_err;
      st_next.o_synced = synced;
      st_next.read_out = 1'b0;
    end
    if (block_read_done) begin
      st_next.read_out = 1'b1;
    end
    // acknowledge restart once; the ack clears the command bit
    st_next.ack = sync_restart_cmd && !st_reg.ack;
    // overflow set wins over read-clear or restart
    if (status_read || st_reg.ack) begin
      st_next.ovf = 1'b0;
    end
    if (synced && block_done && !st_reg.read_out) begin
      st_next.ovf = 1'b1;
    end
    // set by reset detection wins over the status read
    if (status_read) begin
      st_next.rst_seen = 1'b0;
    end
    if (!pres_s) begin
      st_next.rst_seen = 1'b1;
    end
    case (st_reg.st)
      ST_IDLE: begin
        if (fire) begin
          st_next.st = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (strobe_done || status_read) begin
          st_next.st = hold_busy ? ST_HOLD : ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (hold_done || !hold_busy) begin
          st_next.st = ST_IDLE;
        end
      end
      default: st_next.st = ST_IDLE;
    endcase
    st_next.strobe_n = (st_next.st != ST_ACTIVE);
  end

  // flag starts set so the first block is not taken as an overflow
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.st <= ST_IDLE;
      st_reg.pres_prev <= 1'b1;
      st_reg.read_out <= 1'b1;
      st_reg.strobe_n <= 1'b1;
      st_reg.sh_last_id <= ID_INVALID;
      st_reg.sh_prev_id <= ID_INVALID;
      st_reg.o_last_id <= ID_INVALID;
      st_reg.o_prev_id <= ID_INVALID;
      st_reg.sh_last_err <= ERR_UNCORR;
      st_reg.sh_prev_err <= ERR_UNCORR;
      st_reg.o_last_err <= ERR_UNCORR;
      st_reg.o_prev_err <= ERR_UNCORR;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state
  assign last_id = st_reg.o_last_id;
  assign prev_id = st_reg.o_prev_id;
  assign last_word = st_reg.o_last_word;
  assign prev_word = st_reg.o_prev_word;
  assign last_err = st_reg.o_last_err;
  assign prev_err = st_reg.o_prev_err;
  assign status_synced = st_reg.o_synced;
  assign overflow_flag = st_reg.ovf;
  assign reset_seen_flag = st_reg.rst_seen;
  assign iface_write_enable = st_reg.wr;
  assign data_avail_n = st_reg.strobe_n;
  assign sync_restart_ack = st_reg.ack;
  assign good_inc = st_reg.good;
  assign bad_inc = st_reg.bad;
  // bypass passes the row buffer unit through
  assign decoder_out_select = !bypass;

  // helper: cycles since the last release, saturating
  logic [TIMER_W:0] since_wr;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_wr <= '1;
    end else if (st_reg.wr) begin
      since_wr <= '0;
    end else if (since_wr != '1) begin
      since_wr <= since_wr + 1'b1;
    end
  end

  a_bypass_mux: assert property (@(posedge clk) disable iff (!rstn)
    bypass |-> !decoder_out_select) else $error("mux not low in bypass");
  a_bypass_quiet: assert property (@(posedge clk) disable iff (!rstn)
    $past(bypass) |-> !iface_write_enable) else $error("release in bypass");
  a_write_strobe: assert property (@(posedge clk) disable iff (!rstn)
    iface_write_enable |-> !data_avail_n) else $error("release w/o strobe");
  a_ovf_suppress: assert property (@(posedge clk) disable iff (!rstn)
    overflow_flag |=> !iface_write_enable) else $error("write in overflow");
  a_ovf_cause: assert property (@(posedge clk) disable iff (!rstn)
    $rose(overflow_flag) |-> $past(synced && block_done))
    else $error("overflow without synced block");
  a_strobe_drop: assert property (@(posedge clk) disable iff (!rstn)
    !data_avail_n |=> !iface_write_enable) else $error("write in strobe");
  a_hold_window: assert property (@(posedge clk) disable iff (!rstn)
    $rose(iface_write_enable) && $past(since_wr != '1) |->
    $past(since_wr) >= (TIMER_W+1)'(HOLD_CYCLES - 1))
    else $error("data replaced inside hold window");
  a_strobe_release: assert property (@(posedge clk) disable iff (!rstn)
    status_read && !data_avail_n |=> data_avail_n)
    else $error("strobe not released on read");
  a_mode4_search: assert property (@(posedge clk) disable iff (!rstn)
    block_done && sym == SYM_FOUR && !synced && block_err != ERR_NONE
    |=> bad_inc && !good_inc) else $error("search block not bad");
  a_mode4_sync: assert property (@(posedge clk) disable iff (!rstn)
    block_done && sym == SYM_FOUR && synced && block_err == ERR_5BIT
    |=> good_inc && !bad_inc) else $error("synced block not good");
  a_reset_seen: assert property (@(posedge clk) disable iff (!rstn)
    !pres_s |=> reset_seen_flag) else $error("reset seen flag missing");
  a_restart_pulse: assert property (@(posedge clk) disable iff (!rstn)
    sync_restart_ack |=> !sync_restart_ack) else $error("ack not a pulse");

  c_fast_search: cover property (@(posedge clk) disable iff (!rstn)
    osel == OSEL_FAST && !synced && iface_write_enable);
  c_reduced: cover property (@(posedge clk) disable iff (!rstn)
    osel == OSEL_REDUCED && synced && iface_write_enable);
  c_overflow: cover property (@(posedge clk) disable iff (!rstn)
    $rose(overflow_flag));
  c_read_release: cover property (@(posedge clk) disable iff (!rstn)
    status_read && !data_avail_n);
endmodule : rds_output_ctrl
`default_nettype wire

// file: verilog/rds_out_pkg.sv
/*
  shared constants for the radio data output control block: block identity
  and error codes, mode encodings, timing figures and state encodings.
  assumes a 250 MHz system clock.
*/
package rds_out_pkg;
  // clock rate and documented times
  localparam int CLK_MHZ = 250;
  localparam int STROBE_TIME_US = 10000;
  localparam int HOLD_TIME_US = 20000;
  localparam int STROBE_CYC = STROBE_TIME_US * CLK_MHZ;
  localparam int HOLD_CYC = HOLD_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 24;
  localparam int WORD_W = 16;
  // link bits in one block
  localparam logic [4:0] BITS_PER_BLOCK = 5'h1A;
  // block identity codes
  localparam logic [2:0] ID_A = 3'h0;
  localparam logic [2:0] ID_B = 3'h1;
  localparam logic [2:0] ID_C = 3'h2;
  localparam logic [2:0] ID_D = 3'h3;
  localparam logic [2:0] ID_C_PRIME = 3'h4;
  localparam logic [2:0] ID_E_RBDS = 3'h5;
  localparam logic [2:0] ID_E_BAD = 3'h6;
  localparam logic [2:0] ID_INVALID = 3'h7;
  // error status codes
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_2BIT = 2'h1;
  localparam logic [1:0] ERR_5BIT = 2'h2;
  localparam logic [1:0] ERR_UNCORR = 2'h3;
  // output select encodings
  localparam logic [1:0] OSEL_STD = 2'h0;
  localparam logic [1:0] OSEL_FAST = 2'h1;
  localparam logic [1:0] OSEL_REDUCED = 2'h2;
  localparam logic [1:0] OSEL_BYPASS = 2'h3;
  // error-handling mode encodings
  localparam logic [1:0] SYM_NONE = 2'h0;
  localparam logic [1:0] SYM_2BIT = 2'h1;
  localparam logic [1:0] SYM_5BIT = 2'h2;
  localparam logic [1:0] SYM_FOUR = 2'h3;
  // strobe sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_HOLD = 3'b100
  } strobe_state_type;
endpackage : rds_out_pkg

// file: verilog/pin_sync.sv
/*
  two flip-flop synchroniser for pins from outside the clock domain.
  assumes the sampled levels change slower than the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_type;

  sync_state_type st_reg;
  sync_state_type st_next;

  // first stage feeds only the second
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  // reset to the idle level of the pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= {INIT, INIT};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : pin_sync
`default_nettype wire

// file: verilog/down_timer.sv
/*
  loadable down counter; done pulses in the cycle the count is one, the last before it reaches zero.
  assumes start and stop are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module down_timer #(
  parameter int W = 24,
  parameter logic [W-1:0] LOAD = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic stop,
  // status
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_state_type;

  timer_state_type st_reg;
  timer_state_type st_next;

  // start wins over stop so a fresh period is never lost
  always_comb begin
    st_next = st_reg;
    if (start) begin
      st_next.cnt = LOAD;
    end else if (stop) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = (st_reg.cnt != '0);
  assign done = (st_reg.cnt == {{(W-1){1'b0}}, 1'b1}) && !start && !stop;
endmodule : down_timer
`default_nettype wire

// file: dv/rds_ctrl_model.sv
/*
  behavioural model of the main controller on the register side: it answers
  each data-available strobe seen with reads_on high by reading the block data, then the status byte.
  assumes one-cycle read pulses launched on the falling clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module rds_ctrl_model #(
  parameter int READ_DELAY = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // strobe in, read enable from the bench
  input wire logic data_avail_n,
  input wire logic reads_on,
  // read events
  output logic block_read_done,
  output logic status_read
);
  int cnt;
  int phase;
  // prompt controller reads
  // a stalled controller is reads_on low, which is how overflow is provoked
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      phase <= 0;
      block_read_done <= 1'b0;
      status_read <= 1'b0;
    end else begin
      block_read_done <= 1'b0;
      status_read <= 1'b0;
      if (phase == 0 && !data_avail_n && reads_on) begin
        phase <= 1;
        cnt <= 0;
      end else if (phase == 1) begin
        cnt <= cnt + 1;
        if (cnt == READ_DELAY) block_read_done <= 1'b1;
        if (cnt == READ_DELAY + 1) begin
          status_read <= 1'b1;
          phase <= 2;
        end
      end else if (phase == 2 && data_avail_n) begin
        phase <= 0; // strobe gone, wait for the next one
      end
    end
  end
endmodule : rds_ctrl_model
`default_nettype wire

// file: dv/tb_rds_output_ctrl.sv
/*
  self-checking bench for the output control block: drives block events,
  link clock and modes, and checks releases, strobe, flags and counters.
  assumes shortened strobe and hold counts and a 32 ns link clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_rds_output_ctrl
  import rds_out_pkg::*;
;
  logic clk, rstn, rds_bit_clk, power_reset_n, link_on, reads_on;
  logic [1:0] esel, osel;
  logic block_done, synced, seq_pair_found, flywheel_loss;
  logic [2:0] block_id;
  logic [1:0] block_err;
  logic [15:0] block_word;
  logic block_read_done, status_read, sync_restart_cmd, sync_restart_ack;
  logic good_inc, bad_inc, status_synced, overflow_flag, reset_seen_flag;
  logic [2:0] last_id, prev_id;
  logic [15:0] last_word, prev_word;
  logic [1:0] last_err, prev_err;
  logic iface_write_enable, data_avail_n, decoder_out_select, exp_rel;
  int n_fail = 0, n_compared = 0, cycles = 0, n;
  logic [1:0] err_tab [4] = '{ERR_NONE, ERR_2BIT, ERR_5BIT, ERR_UNCORR};
  logic [1:0] osel_tab [3] = '{OSEL_STD, OSEL_FAST, OSEL_REDUCED};
  int gap_tab [3] = '{208, 208, 416};

  rds_output_ctrl #(.STROBE_CYCLES(40), .HOLD_CYCLES(80)) DUT (
    .clk(clk), .rstn(rstn), .rds_bit_clk(rds_bit_clk),
    .power_reset_n(power_reset_n),
    .sync_err_mode_hi(esel[1]), .sync_err_mode_lo(esel[0]),
    .output_mode_sel_hi(osel[1]), .output_mode_sel_lo(osel[0]),
    .block_done(block_done), .block_id(block_id), .block_err(block_err),
    .block_word(block_word), .synced(synced),
    .seq_pair_found(seq_pair_found), .flywheel_loss(flywheel_loss),
    .block_read_done(block_read_done), .status_read(status_read),
    .sync_restart_cmd(sync_restart_cmd),
    .sync_restart_ack(sync_restart_ack), .good_inc(good_inc),
    .bad_inc(bad_inc), .last_id(last_id), .prev_id(prev_id),
    .last_word(last_word), .prev_word(prev_word), .last_err(last_err),
    .prev_err(prev_err), .status_synced(status_synced),
    .overflow_flag(overflow_flag), .reset_seen_flag(reset_seen_flag),
    .iface_write_enable(iface_write_enable), .data_avail_n(data_avail_n),
    .decoder_out_select(decoder_out_select)
  );

  rds_ctrl_model ctrl (
    .clk(clk), .rstn(rstn), .data_avail_n(data_avail_n),
    .reads_on(reads_on), .block_read_done(block_read_done),
    .status_read(status_read)
  );

  // system clock, and a link clock with an unrelated phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rds_bit_clk = 1'b0;
    #3;
    forever #16 if (link_on) rds_bit_clk = ~rds_bit_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // a fresh reset also clears the hold timer between tests
  task automatic do_reset(input int k);
    @(negedge clk);
    rstn = 1'b0;
    {block_done, seq_pair_found, flywheel_loss, sync_restart_cmd} = 4'h0;
    {synced, link_on, reads_on} = 3'b001;
    osel = OSEL_STD;
    power_reset_n = 1'b1;
    cyc(k);
    rstn = 1'b1;
    cyc(2);
  endtask : do_reset

  task automatic send_block(input logic [2:0] id, input logic [1:0] err,
                            input logic [15:0] w);
    @(negedge clk);
    block_done = 1'b1;
    block_id = id;
    block_err = err;
    block_word = w;
    @(negedge clk);
    block_done = 1'b0;
  endtask : send_block

  task automatic fire(input int which);
    @(negedge clk);
    if (which == 0) seq_pair_found = 1'b1;
    else flywheel_loss = 1'b1;
    @(negedge clk);
    seq_pair_found = 1'b0;
    flywheel_loss = 1'b0;
  endtask : fire

  // bounded wait for the next release, cycles counted in n
  task automatic wait_release(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!iface_write_enable && k < 1000);
  endtask : wait_release

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    esel = SYM_FOUR;
    block_id = ID_A;
    block_err = ERR_NONE;
    block_word = 16'h0000;
    do_reset(20);
    check(data_avail_n, 1'b1);
    check(last_id, ID_INVALID);
    check(last_err, ERR_UNCORR);
    check(decoder_out_select, 1'b1);
    // counter steps, searching then synced
    for (int k = 0; k < 4; k++) begin
      synced = k[1];
      send_block(ID_B, err_tab[k], 16'h0000);
      check(good_inc, !k[0]);
      check(bad_inc, k[0]);
    end
    // the other error modes grade a corrected block by burst length
    esel = SYM_2BIT;
    send_block(ID_B, ERR_2BIT, 16'h0000);
    check(good_inc, 1'b1);
    esel = SYM_NONE;
    send_block(ID_B, ERR_2BIT, 16'h0000);
    check(bad_inc, 1'b1);
    esel = SYM_5BIT;
    send_block(ID_B, ERR_5BIT, 16'h0000);
    check(good_inc, 1'b1);
    esel = SYM_FOUR;
    $display("test counter steps done");
    do_reset(3);
    osel = OSEL_FAST;
    for (int k = 0; k < 9; k++) begin
      exp_rel = (k == 0 || k == 4);
      send_block(k[2:0], (k == 8) ? ERR_UNCORR : ERR_NONE, 16'ha500 + 16'(k));
      check(iface_write_enable, exp_rel);
      check(data_avail_n, !exp_rel);
      if (exp_rel) begin
        check(last_id, k[2:0]);
        check(prev_id, (k == 0) ? ID_INVALID : 3'(k - 1));
        check(last_word, 16'ha500 + 16'(k));
        check(last_err, ERR_NONE);
        check(prev_word, (k == 0) ? 16'h0000 : 16'ha4ff + 16'(k));
        check(prev_err, (k == 0) ? ERR_UNCORR : ERR_NONE);
        check(status_synced, 1'b0);
      end
      cyc(100);
      check(data_avail_n, 1'b1);
    end
    $display("test fast search done");
    do_reset(3);
    reads_on = 1'b0;
    send_block(ID_C, ERR_5BIT, 16'h1234);
    fire(0);
    check(iface_write_enable, 1'b1);
    check(last_err, ERR_5BIT);
    send_block(ID_D, ERR_NONE, 16'h5678);
    n = 0;
    while (!data_avail_n && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= 36 && n <= 40), 16'h0001);
    fire(0);
    check(iface_write_enable, 1'b0);
    cyc(100);
    fire(0);
    check(last_id, ID_C);
    $display("test sync criterion done");
    do_reset(3);
    synced = 1'b1;
    link_on = 1'b1;
    fire(0);
    for (int m = 0; m < 3; m++) begin
      osel = osel_tab[m];
      wait_release(n);
      wait_release(n);
      check(16'(n >= gap_tab[m] - 4 && n <= gap_tab[m] + 4), 16'h0001);
    end
    $display("test periodic release done");
    osel = OSEL_STD;
    reads_on = 1'b0;
    wait_release(n);
    send_block(ID_B, ERR_NONE, 16'h0000);
    check(overflow_flag, 1'b1);
    wait_release(n);
    check(16'(n >= 1000), 16'h0001);
    sync_restart_cmd = 1'b1;
    cyc(1);
    check(sync_restart_ack, 1'b1);
    sync_restart_cmd = 1'b0;
    reads_on = 1'b1;
    cyc(1);
    check(sync_restart_ack, 1'b0);
    check(overflow_flag, 1'b0);
    wait_release(n);
    check(16'(n <= 216), 16'h0001);
    $display("test overflow done");
    do_reset(3);
    synced = 1'b1;
    fire(1);
    check(iface_write_enable, 1'b1);
    check(status_synced, 1'b1);
    cyc(100);
    power_reset_n = 1'b0;
    wait_release(n);
    check(16'(n <= 8), 16'h0001);
    check(reset_seen_flag, 1'b1);
    power_reset_n = 1'b1;
    cyc(100);
    check(reset_seen_flag, 1'b0);
    osel = OSEL_BYPASS;
    cyc(1);
    check(decoder_out_select, 1'b0);
    fire(0);
    check(iface_write_enable, 1'b0);
    $display("test loss, power reset and bypass done");
    give_verdict();
  end
endmodule : tb_rds_output_ctrl
`default_nettype wire
